// ### urx_uart_async_receiver.sv
// urx_uart_async_receiver: async serial receiver with APB registers and two-entry FIFO
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module urx_uart_async_receiver
    import urx_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic [11:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // sixteen-times baud tick from the baud generator
    input  wire logic        baud_tick_i,
    // receive pin and its port latch
    input  wire logic        receive_pin_i,
    input  wire logic        rx_pin_direction_bit_i,
    input  wire logic        rx_port_latch_i,
    output logic             receive_pin_o,
    output logic             receive_pin_oe_o,
    // transmit pin, transmitter serial output and port latch
    input  wire logic        tx_serial_i,
    input  wire logic        tx_pin_direction_bit_i,
    input  wire logic        tx_port_latch_i,
    output logic             transmit_pin_o,
    output logic             transmit_pin_oe_o,
    // receive interrupt request
    output logic             irq_o
);

    // decode of an apb address against a register offset
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
        addr_hit = (addr == off);
    endfunction : addr_hit

    // majority of three samples
    function automatic logic majority3(input logic [2:0] s);
        majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority3

    // control and bus state
    urx_ctrl_t   ctrl_ff,       nxt_ctrl;       // software control bits
    logic [31:0] prdata_ff,     nxt_prdata;     // read data
    logic        pready_ff,     nxt_pready;     // access completion
    logic        pslverr_ff,    nxt_pslverr;    // unmapped address
    // pin state
    logic [2:0]  sync_ff;                       // receive pin synchroniser
    logic        line_ff,       nxt_line;       // filtered line level
    logic        line_d_ff;                     // filtered line, one cycle older
    logic [1:0]  vote_ff,       nxt_vote;       // two previous tick samples
    logic        rx_out_ff,     nxt_rx_out;     // receive pin output value
    logic        rx_oe_ff,      nxt_rx_oe;      // receive pin output enable
    logic        tx_out_ff,     nxt_tx_out;     // transmit pin output value
    logic        tx_oe_ff,      nxt_tx_oe;      // transmit pin output enable
    // recovery state
    urx_state_t  state_ff,      nxt_state;      // recovery state
    logic [3:0]  tick_ff,       nxt_tick;       // tick within a bit
    logic [3:0]  bit_ff,        nxt_bit;        // data bit index
    logic [8:0]  shift_ff,      nxt_shift;      // receive shift register
    // fifo state
    urx_char_t   fifo_ff [2];                   // buffered characters
    urx_char_t   nxt_fifo [2];
    logic        rd_ptr_ff,     nxt_rd_ptr;     // oldest entry
    logic        wr_ptr_ff,     nxt_wr_ptr;     // next free entry
    logic [1:0]  count_ff,      nxt_count;      // characters held
    logic        ovr_ff,        nxt_ovr;        // overrun flag
    logic        flag_ff,       nxt_flag;       // receive flag
    logic        irq_ff,        nxt_irq;        // interrupt request
    // combinational helpers
    logic        active;                        // receiver enabled for async
    logic        access;                        // first cycle of an apb access
    logic        pop;                           // data register read
    logic        push;                          // character finished
    urx_char_t   push_char;                     // character being pushed
    logic        vote;                          // majority of the centre samples
    logic [3:0]  last_bit;                      // final data bit index
    urx_char_t   head;                          // oldest character

    assign active   = ctrl_ff.serial_port_enable & ctrl_ff.receive_enable_bit
                      & ~ctrl_ff.sync_select;
    assign access   = psel_i & penable_i & ~pready_ff;
    assign pop      = access & ~pwrite_i & addr_hit(paddr_i, URX_DATA_OFF)
                      & (count_ff != 2'h0);
    assign vote     = majority3({vote_ff, line_ff});
    assign last_bit = ctrl_ff.nine_bit_select ? URX_BIT_LAST9 : URX_BIT_LAST8;
    assign head     = fifo_ff[rd_ptr_ff];

    // apb slave: one wait cycle, writes reach only the control register
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = access;
        nxt_pslverr = 1'b0;
        if (access) begin
            nxt_prdata = 32'h0000_0000;
            if (addr_hit(paddr_i, URX_CTRL_OFF)) begin
                // control register read and write
                if (pwrite_i) begin
                    nxt_ctrl = urx_ctrl_t'(pwdata_i[6:0]);
                end else begin
                    nxt_prdata[6:0] = ctrl_ff;
                end
            end else if (addr_hit(paddr_i, URX_STATUS_OFF)) begin
                // status is read-only, writes are ignored
                if (!pwrite_i) begin
                    nxt_prdata[URX_ST_FLAG]  = flag_ff;
                    nxt_prdata[URX_ST_OVR]   = ovr_ff;
                    nxt_prdata[URX_ST_FRAMING_ERROR_FLAG]  = (count_ff != 2'h0) & head.framing_err;
                    nxt_prdata[URX_ST_NINTH] = (count_ff != 2'h0) & head.data[8];
                    nxt_prdata[URX_ST_BUSY]  = (state_ff != URX_IDLE);
                end
            end else if (addr_hit(paddr_i, URX_DATA_OFF)) begin
                // oldest character, the only way to the buffer
                if (!pwrite_i && count_ff != 2'h0) begin
                    nxt_prdata[7:0] = head.data[7:0];
                end
            end else begin
                // unmapped address
                nxt_pslverr = 1'b1;
            end
        end
    end

    // pin handling: glitch filter and forced directions
    always_comb begin
        nxt_line   = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : line_ff;
        nxt_vote   = baud_tick_i ? {vote_ff[0], line_ff} : vote_ff;
        // receive pin is an input whenever the port is enabled
        nxt_rx_oe  = ~nxt_ctrl.serial_port_enable & ~rx_pin_direction_bit_i;
        nxt_rx_out = rx_port_latch_i;
        // transmit pin is an output, latch disconnected, when the port is enabled
        if (nxt_ctrl.serial_port_enable) begin
            nxt_tx_oe  = 1'b1;
            nxt_tx_out = tx_serial_i;
        end else begin
            nxt_tx_oe  = ~tx_pin_direction_bit_i;
            nxt_tx_out = tx_port_latch_i;
        end
    end

    // recovery state machine
    always_comb begin
        nxt_state = state_ff;
        nxt_tick  = tick_ff;
        nxt_bit   = bit_ff;
        nxt_shift = shift_ff;
        push      = 1'b0;
        push_char = '0;
        if (!active) begin
            nxt_state = URX_IDLE;
        end else begin
            unique case (state_ff)
                URX_IDLE: begin
                    // hunt for a falling edge unless stalled by overrun
                    if (line_d_ff && !line_ff && !ovr_ff) begin
                        nxt_state = URX_START;
                        nxt_tick  = 4'h0;
                    end
                end
                URX_START: begin
                    // check the start bit at its centre
                    if (baud_tick_i) begin
                        nxt_tick = tick_ff + 4'h1;
                        if (tick_ff == URX_TICK_VOTE && vote) begin
                            nxt_state = URX_IDLE;
                        end else if (tick_ff == URX_TICK_LAST) begin
                            nxt_state = URX_DATA;
                            nxt_bit   = 4'h0;
                        end
                    end
                end
                URX_DATA: begin
                    // sample each data bit at its centre, lsb first
                    if (baud_tick_i) begin
                        nxt_tick = tick_ff + 4'h1;
                        if (tick_ff == URX_TICK_VOTE) begin
                            nxt_shift = {vote, shift_ff[8:1]};
                        end
                        if (tick_ff == URX_TICK_LAST) begin
                            if (bit_ff == last_bit) begin
                                nxt_state = URX_STOP;
                            end else begin
                                nxt_bit = bit_ff + 4'h1;
                            end
                        end
                    end
                end
                URX_STOP: begin
                    // stop sample decides framing, then the character is pushed
                    if (baud_tick_i && tick_ff == URX_TICK_VOTE) begin
                        push                  = 1'b1;
                        push_char.framing_err = ~vote;
                        push_char.data        = ctrl_ff.nine_bit_select ? shift_ff
                                                : {1'b0, shift_ff[8:1]};
                        nxt_state             = URX_IDLE;
                    end else if (baud_tick_i) begin
                        nxt_tick = tick_ff + 4'h1;
                    end
                end
            endcase
        end
    end

    // fifo, overrun, flag and interrupt
    always_comb begin
        nxt_fifo   = fifo_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_count  = count_ff;
        nxt_ovr    = ovr_ff & ctrl_ff.receive_enable_bit
                     & ctrl_ff.serial_port_enable;
        if (pop) begin
            nxt_rd_ptr = ~rd_ptr_ff;
            nxt_count  = nxt_count - 2'h1;
        end
        if (push) begin
            if (count_ff == URX_FIFO_DEPTH && !pop) begin
                nxt_ovr = 1'b1;
            end else begin
                nxt_fifo[wr_ptr_ff] = push_char;
                nxt_wr_ptr          = ~wr_ptr_ff;
                nxt_count           = nxt_count + 2'h1;
            end
        end
        if (!ctrl_ff.serial_port_enable) begin
            // port reset empties the buffer and its framing status
            nxt_rd_ptr = 1'b0;
            nxt_wr_ptr = 1'b0;
            nxt_count  = 2'h0;
        end
        nxt_flag = nxt_ctrl.serial_port_enable & nxt_ctrl.receive_enable_bit
                   & ~nxt_ctrl.sync_select & (nxt_count != 2'h0);
        nxt_irq  = nxt_flag & nxt_ctrl.receive_irq_enable
                   & nxt_ctrl.peripheral_irq_enable
                   & nxt_ctrl.global_irq_enable;
    end

    // register stage for every state group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff    <= urx_ctrl_t'(URX_CTRL_RST);
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            sync_ff    <= 3'h7;
            line_ff    <= 1'b1;
            line_d_ff  <= 1'b1;
            vote_ff    <= 2'h3;
            rx_out_ff  <= 1'b0;
            rx_oe_ff   <= 1'b0;
            tx_out_ff  <= 1'b0;
            tx_oe_ff   <= 1'b0;
            state_ff   <= URX_IDLE;
            tick_ff    <= 4'h0;
            bit_ff     <= 4'h0;
            shift_ff   <= 9'h000;
            fifo_ff[0] <= '0;
            fifo_ff[1] <= '0;
            rd_ptr_ff  <= 1'b0;
            wr_ptr_ff  <= 1'b0;
            count_ff   <= 2'h0;
            ovr_ff     <= 1'b0;
            flag_ff    <= 1'b0;
            irq_ff     <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            sync_ff    <= {sync_ff[1:0], receive_pin_i};
            line_ff    <= nxt_line;
            line_d_ff  <= line_ff;
            vote_ff    <= nxt_vote;
            rx_out_ff  <= nxt_rx_out;
            rx_oe_ff   <= nxt_rx_oe;
            tx_out_ff  <= nxt_tx_out;
            tx_oe_ff   <= nxt_tx_oe;
            state_ff   <= nxt_state;
            tick_ff    <= nxt_tick;
            bit_ff     <= nxt_bit;
            shift_ff   <= nxt_shift;
            fifo_ff    <= nxt_fifo;
            rd_ptr_ff  <= nxt_rd_ptr;
            wr_ptr_ff  <= nxt_wr_ptr;
            count_ff   <= nxt_count;
            ovr_ff     <= nxt_ovr;
            flag_ff    <= nxt_flag;
            irq_ff     <= nxt_irq;
        end
    end

    // outputs straight from flip-flops
    assign prdata_o          = prdata_ff;
    assign pready_o          = pready_ff;
    assign pslverr_o         = pslverr_ff;
    assign receive_pin_o     = rx_out_ff;
    assign receive_pin_oe_o  = rx_oe_ff;
    assign transmit_pin_o    = tx_out_ff;
    assign transmit_pin_oe_o = tx_oe_ff;
    assign irq_o             = irq_ff;

    // checks on the design's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a good start centre keeps the recovery in the start state
    sequence start_centre_low;
        active && state_ff == URX_START && baud_tick_i && tick_ff == URX_TICK_VOTE && !vote;
    endsequence
    sequence start_centre_high;
        active && state_ff == URX_START && baud_tick_i && tick_ff == URX_TICK_VOTE && vote;
    endsequence

    start_keep_a: assert property (start_centre_low |=> state_ff == URX_START)
        else $error("start bit lost after a low centre sample");
    // a read or a control write in the same cycle may legally move the count
    start_abort_a: assert property (start_centre_high
        ##0 (!pop && ctrl_ff == nxt_ctrl) |=>
        state_ff == URX_IDLE && ovr_ff == $past(ovr_ff) && count_ff == $past(count_ff))
        else $error("false start not abandoned silently");
    edge_start_a: assert property (active && state_ff == URX_IDLE && line_d_ff && !line_ff
        && !ovr_ff |=> state_ff == URX_START && tick_ff == 4'h0)
        else $error("falling edge did not start a character");
    data_step_a: assert property (active && state_ff == URX_DATA && baud_tick_i
        && tick_ff == URX_TICK_LAST && bit_ff == last_bit |=> state_ff == URX_STOP)
        else $error("stop position not reached after last data bit");
    fifo_bound_a: assert property (count_ff <= URX_FIFO_DEPTH)
        else $error("buffer holds more than two characters");
    overrun_set_a: assert property (push && count_ff == URX_FIFO_DEPTH && !pop
        && ctrl_ff == nxt_ctrl |=> ovr_ff && count_ff == URX_FIFO_DEPTH)
        else $error("overrun not flagged on a third character");
    overrun_stall_a: assert property (ovr_ff && state_ff == URX_IDLE |=>
        state_ff == URX_IDLE)
        else $error("reception resumed while overrun stands");
    flag_level_a: assert property (flag_ff == (active && count_ff != 2'h0))
        else $error("receive flag disagrees with occupancy");
    push_flag_a: assert property (push && !pop && ctrl_ff == nxt_ctrl |=> flag_ff)
        else $error("flag not raised after a character arrived");
    pop_order_a: assert property (pop && !push |=> count_ff == $past(count_ff) - 2'h1
        && rd_ptr_ff != $past(rd_ptr_ff))
        else $error("read did not remove the oldest character");
    irq_gate_a: assert property (irq_o |-> flag_ff && ctrl_ff.receive_irq_enable
        && ctrl_ff.peripheral_irq_enable && ctrl_ff.global_irq_enable)
        else $error("interrupt without all enables");
    pin_dir_a: assert property (ctrl_ff.serial_port_enable |->
        !receive_pin_oe_o && transmit_pin_oe_o)
        else $error("pin directions not forced by port enable");

endmodule : urx_uart_async_receiver

// ### urx_pkg.sv
// urx_pkg: register map, field layouts and timing constants of the async receiver
// Behaviour
// - line oversampled at sixteen ticks per bit
// - finished characters enter a two-entry FIFO
// - characters reachable only through receive data register
// - runs only with receive, port enabled, async
// - port enable forces receive pin to input
// - port enable forces transmit pin output, latch cut
// - falling line edge starts a character
// - half a bit later start must be low
// - high start centre aborts silently, hunt again
// - each data bit voted at centre, shifted in
// - stop sample low sets framing error, else clear
// - after stop, push character and raise flag
// - data read returns and removes oldest character
// - after overrun, no further characters are accepted
// - flag high while enabled and characters unread
// - receive flag ignores software writes
// - interrupt needs all three enables set
// - flag follows occupancy regardless of interrupt enables
// - third character on full FIFO sets overrun
// - framing bit stored per character, oldest shown
// - nine-bit mode shifts nine, ninth bit readable
package urx_pkg;

    // register byte offsets
    localparam logic [11:0] URX_CTRL_OFF   = 12'h000;
    localparam logic [11:0] URX_STATUS_OFF = 12'h004;
    localparam logic [11:0] URX_DATA_OFF   = 12'h008;

    // control register reset value
    localparam logic [6:0]  URX_CTRL_RST   = 7'h00;

    // status register bit positions
    localparam int          URX_ST_FLAG    = 0;
    localparam int          URX_ST_OVR     = 1;
    localparam int          URX_ST_FRAMING_ERROR_FLAG    = 2;
    localparam int          URX_ST_NINTH   = 3;
    localparam int          URX_ST_BUSY    = 4;

    // oversampling timing, in baud ticks within one bit
    localparam logic [3:0]  URX_TICK_VOTE  = 4'h8;   // third tick of the centre vote
    localparam logic [3:0]  URX_TICK_LAST  = 4'hF;   // last tick of a bit time
    localparam logic [3:0]  URX_BIT_LAST8  = 4'h7;   // last data bit, eight-bit mode
    localparam logic [3:0]  URX_BIT_LAST9  = 4'h8;   // last data bit, nine-bit mode
    localparam logic [1:0]  URX_FIFO_DEPTH = 2'h2;   // buffered characters

    // control register layout, bit 0 is the last field
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic receive_irq_enable;
        logic nine_bit_select;
        logic sync_select;
        logic receive_enable_bit;
        logic serial_port_enable;
    } urx_ctrl_t;

    // one buffered character with its framing status
    typedef struct packed {
        logic       framing_err;
        logic [8:0] data;
    } urx_char_t;

    // recovery state machine
    typedef enum logic [1:0] {
        URX_IDLE  = 2'b00,
        URX_START = 2'b01,
        URX_DATA  = 2'b10,
        URX_STOP  = 2'b11
    } urx_state_t;

endpackage : urx_pkg

// ### urx_line_model.sv
// urx_line_model: far-end asynchronous transmitter that drives the receive line
`timescale 1ns/100ps
module urx_line_model (
    // clock and oversampling tick
    input  wire logic clk_i,
    input  wire logic tick_i,
    // serial line towards the receiver
    output logic      line_o
);
    // the line rests high between frames
    initial line_o = 1'b1;

    // wait a number of oversampling ticks
    task ticks(input int n);
        repeat (n) begin
            do @(posedge clk_i); while (tick_i !== 1'b1);
        end
    endtask : ticks

    // one frame: low start, data lsb first, chosen stop level
    task send(input logic [8:0] d, input int nb, input logic stop);
        line_o <= 1'b0;
        ticks(16);
        for (int i = 0; i < nb; i++) begin
            line_o <= d[i];
            ticks(16);
        end
        line_o <= stop;
        ticks(16);
        line_o <= 1'b1;
        ticks(4);
    endtask : send

    // low pulse that is gone before the start centre
    task glitch();
        line_o <= 1'b0;
        ticks(4);
        line_o <= 1'b1;
        ticks(20);
    endtask : glitch
endmodule : urx_line_model

// ### test_uart_async_receiver.sv
// test_uart_async_receiver: self-checking bench for the async receiver
`timescale 1ns/100ps
module test_uart_async_receiver;
    import urx_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        tick = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, err, line, rxo, rxoe, txo, txoe, irq;
    logic [1:0]  tcnt = 2'h0;
    int          checks = 0;
    int          mismatches = 0;

    // 200 MHz clock and a baud tick every fourth cycle
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    urx_uart_async_receiver DUT (.clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .baud_tick_i(tick),
        .receive_pin_i(line), .rx_pin_direction_bit_i(1'b0), .rx_port_latch_i(1'b1),
        .receive_pin_o(rxo), .receive_pin_oe_o(rxoe), .tx_serial_i(1'b0),
        .tx_pin_direction_bit_i(1'b1), .tx_port_latch_i(1'b1), .transmit_pin_o(txo),
        .transmit_pin_oe_o(txoe), .irq_o(irq));
    urx_line_model M (.clk_i(clk_i), .tick_i(tick), .line_o(line));

    // compare one value and count it
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // counts and verdict, then stop
    task print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    // one apb transfer, waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin
            mismatches++;
            print_verdict();
        end
    endtask : apb

    // reset values, pin steering, enables and unmapped access
    task t_regs();
        chk("pins_idle", 32'({rxoe, rxo, txoe, txo}), 32'hD);
        apb(1'b0, URX_CTRL_OFF, 32'h0);
        chk("ctrl_reset", r, 32'h0);
        apb(1'b1, URX_CTRL_OFF, 32'h07);
        apb(1'b0, URX_CTRL_OFF, 32'h0);
        chk("ctrl_rw", r, 32'h07);
        chk("pins", 32'({rxoe, txoe, txo}), 32'h2);
        M.send(9'h055, 8, 1'b1);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("sync_blocks", r, 32'h0);
        apb(1'b0, 12'hFF0, 32'h0);
        chk("unmapped", {r[30:0], err}, 32'h1);
        $display("test regs done");
    endtask : t_regs

    // two frames, framing status per character, read order, glitch
    task t_frames();
        apb(1'b1, URX_CTRL_OFF, 32'h03);
        M.send(9'h0A5, 8, 1'b1);
        M.send(9'h03C, 8, 1'b0);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("two_held", r, 32'h01);
        apb(1'b1, URX_STATUS_OFF, 32'h0);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("flag_ro", r, 32'h01);
        apb(1'b0, URX_DATA_OFF, 32'h0);
        chk("first", r, 32'hA5);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("framing_error_flag_second", r, 32'h05);
        apb(1'b0, URX_DATA_OFF, 32'h0);
        chk("second", r, 32'h3C);
        M.glitch();
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("glitch", r, 32'h0);
        $display("test frames done");
    endtask : t_frames

    // third frame on a full buffer, then recovery
    task t_overrun();
        M.send(9'h011, 8, 1'b1);
        M.send(9'h022, 8, 1'b1);
        M.send(9'h033, 8, 1'b1);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("overrun", r, 32'h03);
        apb(1'b1, URX_CTRL_OFF, 32'h01);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("rx_off", r, 32'h0);
        apb(1'b1, URX_CTRL_OFF, 32'h03);
        apb(1'b0, URX_DATA_OFF, 32'h0);
        chk("kept1", r, 32'h11);
        apb(1'b0, URX_DATA_OFF, 32'h0);
        chk("kept2", r, 32'h22);
        apb(1'b0, URX_DATA_OFF, 32'h0);
        chk("dropped", r, 32'h0);
        $display("test overrun done");
    endtask : t_overrun

    // nine-bit frame and interrupt gating
    task t_irq();
        apb(1'b1, URX_CTRL_OFF, 32'h6B);
        M.send(9'h1A5, 9, 1'b1);
        apb(1'b0, URX_STATUS_OFF, 32'h0);
        chk("ninth", r, 32'h09);
        chk("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, URX_CTRL_OFF, 32'h7B);
        chk("irq_on", 32'(irq), 32'h1);
        apb(1'b0, URX_DATA_OFF, 32'h0);
        chk("low_byte", r, 32'hA5);
        repeat (2) @(posedge clk_i);
        chk("irq_off", 32'(irq), 32'h0);
        $display("test irq done");
    endtask : t_irq

    // watchdog: a hang anywhere counts as a mismatch and ends the run
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end

    // reset, then the scenarios
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // pin registers load at the first edge after release, settled by the second
        repeat (2) @(posedge clk_i);
        t_regs();
        t_frames();
        t_overrun();
        t_irq();
        print_verdict();
    end
endmodule : test_uart_async_receiver
